// [logic/rpss_pkg.sv]
// Constants and types for the remote point state supervision block
package rpss_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
   localparam int unsigned PAIRS_TOTAL = 128;
   localparam int unsigned PAIRS_PRE = 32;
   localparam int unsigned PAIRS_USER = 32;
   localparam int unsigned USER_BASE = 32;
   localparam int unsigned N_DEV = 16;
   localparam int unsigned N_RIN = 32;
   localparam int unsigned N_ROUT = 64;
   localparam int unsigned ID_W = 32;
   localparam int unsigned TIME_W = 16;
   localparam int unsigned HOLD_MULT = 3;
   // Register index map (word addresses)
   localparam logic [7:0] A_LOCAL_ID = 8'h00;
   localparam logic [7:0] A_UPDATE = 8'h01;
   localparam logic [7:0] A_STATUS = 8'h02;
   localparam logic [7:0] A_RIN_VAL = 8'h03;
   localparam logic [7:0] A_TX_CNT = 8'h04;
   localparam logic [7:0] A_DEV_ID = 8'h10;
   localparam logic [7:0] A_RIN_CFG = 8'h20;
   localparam logic [7:0] A_ROUT_LO = 8'h40;
   localparam logic [7:0] A_ROUT_HI = 8'h41;
   localparam logic [15:0] UPDATE_RST = 16'h03e8;
   // Remote input config word layout
   localparam int unsigned CFG_DEV_LSB = 0;
   localparam int unsigned CFG_PAIR_LSB = 4;
   localparam int unsigned CFG_DEF_LSB = 10;
   typedef enum logic [1:0] {
      DEF_ON = 2'h0,
      DEF_OFF = 2'h1,
      DEF_LATEST_ON = 2'h2,
      DEF_LATEST_OFF = 2'h3
   } default_mode_e;
endpackage

// [logic/remote_point_state_supervision.sv]
// Remote point state exchange: message framer, filter and hold timers
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module remote_point_state_supervision
   import rpss_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   input wire logic RX_VALID_IN,
   input wire logic [ID_W-1:0] RX_ID_IN,
   input wire logic [TIME_W-1:0] RX_HOLD_IN,
   input wire logic [2*PAIRS_TOTAL-1:0] RX_PAIRS_IN,
   input wire logic TX_READY_IN,
   output logic TX_VALID_OUT,
   output logic [ID_W-1:0] TX_ID_OUT,
   output logic [TIME_W-1:0] TX_HOLD_OUT,
   output logic [2*PAIRS_TOTAL-1:0] TX_PAIRS_OUT,
   output logic [N_RIN-1:0] RIN_OUT,
   output logic [N_DEV-1:0] OFFLINE_OUT
);
   // Transmit side in brief
   // One message is built at a time and held on the port
   // Valid stays up until the link raises ready
   // The whole message is captured in flops at the trigger
   // So a write during a send never tears a message
   // Changes made while sending go out in the next one
   // Only two states; the codes differ in one bit
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01
   } tx_state_e;

   // Point value of a received pair is its low bit
   // The high bit is the complement and is not checked
   // A torn pair therefore reads as its low bit only
   // Selections 0..31 land on predefined_status_pairs
   // Selections 32..63 land on user_status_pairs 1..32
   // Pairs above 63 can never be selected
   // Pair select: 0..31 predefined, 32..63 user pairs at message pair 32+
   function automatic logic pair_bit(input logic [2*PAIRS_TOTAL-1:0] pairs, input logic [5:0] sel);
      logic [6:0] idx;
      idx = {1'b0, sel};
      pair_bit = pairs[{idx, 1'b0}];
   endfunction

   // Storage
   // Settings: own identity, update interval, sixteen
   // remote identities and thirty-two input configs
   // Runtime: hold counters, offline mask, input values
   // and the flag that a value has ever been received
   // Transmit: pending flag, interval counter, message
   // All of it is plain flip-flops indexed by number
   logic [ID_W-1:0] local_id_reg;
   logic [ID_W-1:0] tx_id_reg;
   logic [TIME_W-1:0] update_reg;
   logic [ID_W-1:0] dev_id_reg [N_DEV];
   logic [11:0] rin_cfg_reg [N_RIN];
   logic [N_ROUT-1:0] rout_reg;
   logic [N_ROUT-1:0] rout_sent_reg;
   logic [TIME_W-1:0] hold_cnt_reg [N_DEV];
   logic [N_DEV-1:0] offline_reg;
   logic [N_RIN-1:0] rin_reg;
   logic [N_RIN-1:0] known_reg;
   logic [31:0] tick_cnt_reg;
   logic tick_reg;
   logic [TIME_W-1:0] upd_cnt_reg;
   logic pend_reg;
   logic [15:0] tx_cnt_reg;
   tx_state_e tx_state_reg;
   logic [31:0] rdata_reg;
   logic tx_valid_reg;
   logic [TIME_W-1:0] tx_hold_reg;
   logic [2*PAIRS_TOTAL-1:0] tx_pairs_reg;

   // Every message on the link is looked at
   // Each device slot compares its whole identity
   // Two slots holding one identity both accept
   // Slots left at reset hold zero and match zero
   // Software must give unused slots a spare identity
   // if a zero originator can appear on the network
   // The compare is combinational and one cycle wide
   // Originator match against all sixteen configured identities
   logic [N_DEV-1:0] rx_match;
   genvar gd;
   for (gd = 0; gd < N_DEV; gd++) begin : g_match
      assign rx_match[gd] = RX_VALID_IN && (RX_ID_IN == dev_id_reg[gd]);
   end

   // Each input names one device slot and one pair
   // Take is high when that slot matched this cycle
   // New is the pair's value in the present message
   // Both are only meaningful while valid is high
   // Sixteen-way and 64-way selects per input
   // This is the widest logic in the block
   // Kept combinational; the result is registered below
   // Point value each remote input would take from the current message
   logic [N_RIN-1:0] rin_take;
   logic [N_RIN-1:0] rin_new;
   genvar gi;
   for (gi = 0; gi < N_RIN; gi++) begin : g_rin
      wire logic [3:0] dsel = rin_cfg_reg[gi][CFG_DEV_LSB +: 4];
      wire logic [5:0] psel = rin_cfg_reg[gi][CFG_PAIR_LSB +: 6];
      assign rin_take[gi] = rx_match[dsel];
      assign rin_new[gi] = pair_bit(RX_PAIRS_IN, psel);
   end

   // Register map decode
   // Device identities sit in a block of sixteen words
   // Input configs sit in a block of thirty-two words
   // Scalar registers are decoded by full address
   // Change detect compares outputs against last sent
   // Interval expiry only counts on a tick
   // Hold time is cut to the counter width on purpose
   // Address decode for the per-index register groups
   wire logic dev_sel = (ADDR_IN[7:4] == A_DEV_ID[7:4]);
   wire logic cfg_sel = (ADDR_IN[7:5] == A_RIN_CFG[7:5]);
   wire logic [3:0] dev_idx = ADDR_IN[3:0];
   wire logic [4:0] cfg_idx = ADDR_IN[4:0];
   wire logic rout_changed = (rout_reg != rout_sent_reg);
   wire logic upd_expired = tick_reg && (upd_cnt_reg <= 16'h0001);
   wire logic tx_fire = (tx_state_reg == TX_IDLE) && (pend_reg || rout_changed || upd_expired);
   wire logic [TIME_W-1:0] hold_time = TIME_W'(update_reg * HOLD_MULT);

   // Read selection
   // Block groups are checked before scalar addresses
   // Status and input values are read only
   // Sent count wraps silently at sixteen bits
   // A read has no side effects on any state
   // Read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (dev_sel) begin
         rd_mux = dev_id_reg[dev_idx];
      end else if (cfg_sel) begin
         rd_mux = {20'h00000, rin_cfg_reg[cfg_idx]};
      end else begin
         case (ADDR_IN)
            A_LOCAL_ID: rd_mux = local_id_reg;
            A_UPDATE: rd_mux = {16'h0000, update_reg};
            A_STATUS: rd_mux = {16'h0000, offline_reg};
            A_RIN_VAL: rd_mux = rin_reg;
            A_TX_CNT: rd_mux = {16'h0000, tx_cnt_reg};
            A_ROUT_LO: rd_mux = rout_reg[31:0];
            A_ROUT_HI: rd_mux = rout_reg[63:32];
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Register port
   // Read data stands for exactly one cycle
   // and is zero in every other cycle
   // Writes land at the strobe edge
   // Unmapped and read-only addresses ignore writes
   // A new update interval applies from the next send
   // A new own identity applies from the next send
   // Register writes and read data one cycle later
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         local_id_reg <= '0;
         update_reg <= UPDATE_RST;
         rout_reg <= '0;
         rdata_reg <= '0;
         for (int i = 0; i < N_DEV; i++) begin
            dev_id_reg[i] <= '0;
         end
         for (int i = 0; i < N_RIN; i++) begin
            rin_cfg_reg[i] <= '0;
         end
      end else begin
         rdata_reg <= RD_IN ? rd_mux : 32'h0000_0000;
         if (WR_IN) begin
            if (dev_sel) begin
               dev_id_reg[dev_idx] <= WDATA_IN;
            end else if (cfg_sel) begin
               rin_cfg_reg[cfg_idx] <= WDATA_IN[11:0];
            end else if (ADDR_IN == A_LOCAL_ID) begin
               local_id_reg <= WDATA_IN;
            end else if (ADDR_IN == A_UPDATE) begin
               update_reg <= WDATA_IN[15:0];
            end else if (ADDR_IN == A_ROUT_LO) begin
               rout_reg[31:0] <= WDATA_IN;
            end else if (ADDR_IN == A_ROUT_HI) begin
               rout_reg[63:32] <= WDATA_IN;
            end
         end
      end
   end

   // Time base
   // One pulse every TICK_DIV clocks
   // All hold and interval counts are in ticks
   // Sharing the divider saves sixteen prescalers
   // The price is up to one tick of jitter on
   // the first decrement after a load
   // Common time-base tick; one divider shared by every timer
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg >= TICK_DIV - 1) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         tick_reg <= 1'b0;
      end
   end

   // Hold supervision
   // A matching message loads the carried hold time
   // and brings the device online at once
   // A zero hold time leaves the device offline
   // Online counters step down on each tick
   // The tick that finds one or less marks it offline
   // Offline counters stay put until the next message
   // A single lost message is tolerated when the sender
   // uses three times its interval as hold time
   // Per-device hold timers; a fresh message beats an expiry in the same cycle
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         offline_reg <= '1;
         for (int d = 0; d < N_DEV; d++) begin
            hold_cnt_reg[d] <= '0;
         end
      end else begin
         for (int d = 0; d < N_DEV; d++) begin
            if (rx_match[d]) begin
               hold_cnt_reg[d] <= RX_HOLD_IN;
               offline_reg[d] <= (RX_HOLD_IN == '0);
            end else if (tick_reg && !offline_reg[d]) begin
               hold_cnt_reg[d] <= hold_cnt_reg[d] - 16'h0001;
               if (hold_cnt_reg[d] <= 16'h0001) begin
                  offline_reg[d] <= 1'b1;
               end
            end
         end
      end
   end

   // Remote input values
   // A message from the source slot sets the value
   // and notes that a value is now known
   // While the source is offline the default applies
   // every cycle, so a changed mode acts at once
   // Hold-last modes keep the known value
   // and fall back to one or zero if none is known
   // While the source is online and silent the
   // value simply stays as last received
   // Remote inputs: message value, else default while source is offline
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         known_reg <= '0;
         for (int i = 0; i < N_RIN; i++) begin
            rin_reg[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < N_RIN; i++) begin
            if (rin_take[i]) begin
               rin_reg[i] <= rin_new[i];
               known_reg[i] <= 1'b1;
            end else if (offline_reg[rin_cfg_reg[i][CFG_DEV_LSB +: 4]]) begin
               case (default_mode_e'(rin_cfg_reg[i][CFG_DEF_LSB +: 2]))
                  DEF_ON: rin_reg[i] <= 1'b1;
                  DEF_OFF: rin_reg[i] <= 1'b0;
                  DEF_LATEST_ON: rin_reg[i] <= known_reg[i] ? rin_reg[i] : 1'b1;
                  DEF_LATEST_OFF: rin_reg[i] <= known_reg[i] ? rin_reg[i] : 1'b0;
                  default: rin_reg[i] <= 1'b0;
               endcase
            end
         end
      end
   end

   // Transmit scheduling
   // Three triggers: power-up, change, interval
   // Power-up is a pending flag set by reset
   // A change is any output differing from last sent
   // The interval counter pauses while sending
   // An expiry seen while sending is kept as pending
   // Identity, hold time and pairs are captured together
   // Unused pairs are sent as zero
   // The link sees an idle cycle between messages
   // Sent count steps once per handshake
   // Transmit scheduler; a message is held until the link takes it
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         pend_reg <= 1'b1;
         upd_cnt_reg <= UPDATE_RST;
         tx_state_reg <= TX_IDLE;
         tx_valid_reg <= 1'b0;
         tx_hold_reg <= '0;
         tx_id_reg <= '0;
         tx_pairs_reg <= '0;
         rout_sent_reg <= '0;
         tx_cnt_reg <= '0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               if (tx_fire) begin
                  pend_reg <= 1'b0;
                  tx_valid_reg <= 1'b1;
                  tx_hold_reg <= hold_time;
                  tx_id_reg <= local_id_reg; // identity frozen per message
                  tx_pairs_reg <= '0; // unused pairs stay zero
                  for (int k = 0; k < PAIRS_PRE; k++) begin
                     tx_pairs_reg[2*k +: 2] <= {~rout_reg[k], rout_reg[k]};
                  end
                  for (int k = 0; k < PAIRS_USER; k++) begin
                     tx_pairs_reg[2*(USER_BASE+k) +: 2] <= {~rout_reg[PAIRS_PRE+k], rout_reg[PAIRS_PRE+k]};
                  end
                  rout_sent_reg <= rout_reg;
                  upd_cnt_reg <= update_reg; // Any send restarts the interval
                  tx_state_reg <= TX_SEND;
               end else if (tick_reg) begin
                  upd_cnt_reg <= upd_cnt_reg - 16'h0001;
               end
            end
            TX_SEND: begin
               if (TX_READY_IN) begin
                  tx_valid_reg <= 1'b0;
                  tx_cnt_reg <= tx_cnt_reg + 16'h0001;
                  tx_state_reg <= TX_IDLE;
               end
               if (upd_expired) begin
                  pend_reg <= 1'b1; // Interval lapsed mid-send, not lost
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // Outputs
   // Every port below is a flop, no logic after it
   // Message fields only change at a trigger
   // Identity is the copy taken at the trigger,
   // so a write during a send cannot change it
   assign RDATA_OUT = rdata_reg;
   assign TX_VALID_OUT = tx_valid_reg;
   assign TX_ID_OUT = tx_id_reg;
   assign TX_HOLD_OUT = tx_hold_reg;
   assign TX_PAIRS_OUT = tx_pairs_reg;
   assign RIN_OUT = rin_reg;
   assign OFFLINE_OUT = offline_reg;
endmodule

// [dv/rpss_checker.sv]
// Port-level assertions for the remote point state supervision block
`timescale 1ns/10ps
module rpss_checker
   import rpss_pkg::*;
#(
   parameter int unsigned TICK_DIV = 4
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [31:0] RDATA_OUT,
   input wire logic RX_VALID_IN,
   input wire logic [ID_W-1:0] RX_ID_IN,
   input wire logic [TIME_W-1:0] RX_HOLD_IN,
   input wire logic TX_READY_IN,
   input wire logic TX_VALID_OUT,
   input wire logic [ID_W-1:0] TX_ID_OUT,
   input wire logic [TIME_W-1:0] TX_HOLD_OUT,
   input wire logic [2*PAIRS_TOTAL-1:0] TX_PAIRS_OUT,
   input wire logic [N_DEV-1:0] OFFLINE_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   logic [15:0] upd_reg;
   logic [31:0] id0_reg;
   logic pair_ok;
   wire logic [TIME_W-1:0] hold_exp = TIME_W'(HOLD_MULT * upd_reg);
   // Shadow copies; a write during a send would blur the hold check
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         upd_reg <= UPDATE_RST;
         id0_reg <= '0;
      end else if (WR_IN && ADDR_IN == A_UPDATE) begin
         upd_reg <= WDATA_IN[15:0];
      end else if (WR_IN && ADDR_IN == A_DEV_ID) begin
         id0_reg <= WDATA_IN;
      end
   end
   // Each used pair must be complementary
   always_comb begin
      pair_ok = 1'b1;
      for (int k = 0; k < 64; k++) begin
         if (TX_PAIRS_OUT[2*k+1] == TX_PAIRS_OUT[2*k]) pair_ok = 1'b0;
      end
   end
   property p_rd_idle; !$past(RD_IN) |-> RDATA_OUT == '0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_status; $past(RD_IN) && $past(ADDR_IN) == A_STATUS |-> RDATA_OUT[15:0] == $past(OFFLINE_OUT);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");
   property p_tx_hold;
      TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_PAIRS_OUT) && $stable(TX_ID_OUT)
         && $stable(TX_HOLD_OUT);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("message changed before taken");
   property p_tx_gap; TX_VALID_OUT && TX_READY_IN |=> !TX_VALID_OUT; endproperty
   a_tx_gap: assert property (p_tx_gap) else $error("no idle after send");
   property p_tx_time; TX_VALID_OUT |-> TX_HOLD_OUT == hold_exp; endproperty
   a_tx_time: assert property (p_tx_time) else $error("hold time wrong");
   property p_tx_upper; TX_VALID_OUT |-> TX_PAIRS_OUT[255:128] == '0; endproperty
   a_tx_upper: assert property (p_tx_upper) else $error("unused pairs not zero");
   property p_tx_pair; TX_VALID_OUT |-> pair_ok; endproperty
   a_tx_pair: assert property (p_tx_pair) else $error("pair not complementary");
   property p_rx_load; RX_VALID_IN && RX_ID_IN == id0_reg && RX_HOLD_IN >= 3 |=> !OFFLINE_OUT[0] [*4];
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("device not online after message");
   property p_rx_match; $fell(OFFLINE_OUT[0]) |-> $past(RX_VALID_IN) && $past(RX_ID_IN) == id0_reg;
   endproperty
   a_rx_match: assert property (p_rx_match) else $error("online without matching message");
endmodule
bind remote_point_state_supervision rpss_checker #(.TICK_DIV(TICK_DIV)) chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .RX_VALID_IN(RX_VALID_IN), .RX_ID_IN(RX_ID_IN), .RX_HOLD_IN(RX_HOLD_IN), .TX_READY_IN(TX_READY_IN),
   .TX_VALID_OUT(TX_VALID_OUT), .TX_ID_OUT(TX_ID_OUT), .TX_HOLD_OUT(TX_HOLD_OUT), .TX_PAIRS_OUT(TX_PAIRS_OUT),
   .OFFLINE_OUT(OFFLINE_OUT));

// [dv/rpss_remote_relay.sv]
// Far-side relay model: sends messages to the block and takes its own
`timescale 1ns/10ps
module rpss_remote_relay
   import rpss_pkg::*;
(
   input wire logic clk_in,
   input wire logic tx_valid_in,
   input wire logic [ID_W-1:0] tx_id_in,
   input wire logic [TIME_W-1:0] tx_hold_in,
   input wire logic [255:0] tx_pairs_in,
   output logic rx_valid_out,
   output logic [ID_W-1:0] rx_id_out,
   output logic [TIME_W-1:0] rx_hold_out,
   output logic [255:0] rx_pairs_out,
   output logic tx_ready_out
);
   int lat = 0;
   int wait_cnt = 0;
   int got_cnt = 0;
   logic [ID_W-1:0] got_id;
   logic [TIME_W-1:0] got_hold;
   logic [255:0] got_pairs;
   initial begin
      rx_valid_out = 1'b0;
      rx_id_out = '1;
      rx_hold_out = '1;
      rx_pairs_out = '1;
      tx_ready_out = 1'b0;
   end
   // Take an offered message after lat cycles; slow answers stretch the hold
   always @(posedge clk_in) begin
      tx_ready_out <= 1'b0;
      if (tx_valid_in && tx_ready_out) begin
         got_id <= tx_id_in;
         got_hold <= tx_hold_in;
         got_pairs <= tx_pairs_in;
         got_cnt <= got_cnt + 1;
      end else if (tx_valid_in && wait_cnt >= lat) begin
         tx_ready_out <= 1'b1;
         wait_cnt <= 0;
      end else if (tx_valid_in) begin
         wait_cnt <= wait_cnt + 1;
      end
   end
   // One message for one cycle; the lines then show the inverse
   task automatic send(input logic [31:0] id, input logic [15:0] hold, input logic [255:0] pairs);
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_id_out <= id;
      rx_hold_out <= hold;
      rx_pairs_out <= pairs;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_id_out <= ~id;
      rx_hold_out <= ~hold;
      rx_pairs_out <= ~pairs;
      #1;
   endtask
endmodule

// [dv/tb_remote_point_state_supervision.sv]
// Testbench: register tasks, message exchange and hold timer scenarios
`timescale 1ns/10ps
module tb_remote_point_state_supervision
   import rpss_pkg::*;
;
   logic clk = 0, rst = 1, wr = 0, rd = 0, rx_valid, tx_ready, tx_valid;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0, rdata, rx_id, tx_id, d;
   logic [15:0] rx_hold, tx_hold, offline;
   logic [255:0] rx_pairs, tx_pairs;
   logic [31:0] rin;
   logic [11:0] cfg [5] = '{12'h430, 12'h210, 12'h850, 12'hc60, 12'h43f};
   int error_cnt = 0, compares = 0, n;
   remote_point_state_supervision #(.TICK_DIV(4)) uut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_VALID_IN(rx_valid), .RX_ID_IN(rx_id),
      .RX_HOLD_IN(rx_hold), .RX_PAIRS_IN(rx_pairs), .TX_READY_IN(tx_ready), .TX_VALID_OUT(tx_valid),
      .TX_ID_OUT(tx_id), .TX_HOLD_OUT(tx_hold), .TX_PAIRS_OUT(tx_pairs), .RIN_OUT(rin), .OFFLINE_OUT(offline));
   rpss_remote_relay p (.clk_in(clk), .tx_valid_in(tx_valid), .tx_id_in(tx_id), .tx_hold_in(tx_hold),
      .tx_pairs_in(tx_pairs), .rx_valid_out(rx_valid), .rx_id_out(rx_id), .rx_hold_out(rx_hold),
      .rx_pairs_out(rx_pairs), .tx_ready_out(tx_ready));
   initial forever #4 clk = ~clk;
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait for the far side to take one message
   task automatic wait_tx(input int lim);
      int c0;
      c0 = p.got_cnt;
      for (int i = 0; i < lim && p.got_cnt == c0; i++) begin
         @(posedge clk);
         #1;
      end
      chk("tx_taken", 1, p.got_cnt != c0);
      if (p.got_cnt == c0) print_verdict();
   endtask
   // Pair k carries {~v,v}; same coding in both directions
   function automatic logic [255:0] pr(input logic [63:0] r);
      pr = '0;
      for (int k = 0; k < 64; k++) pr[2*k+:2] = {~r[k], r[k]};
   endfunction
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wait_tx(20);
      chk("hold", 3000, p.got_hold);
      chk("offline", 16'hffff, offline);
      wr_reg(A_UPDATE, 5);
      wr_reg(A_LOCAL_ID, 32'h5a5a0001);
      wr_reg(A_ROUT_LO, 32'h13);
      wr_reg(A_ROUT_HI, 32'h80000001);
      p.lat = 3;
      repeat (30) @(posedge clk);
      wait_tx(40);
      chk("pairs", pr(64'h80000001_00000013), p.got_pairs);
      chk("id", 32'h5a5a0001, p.got_id);
      chk("hold", 15, p.got_hold);
      n = p.got_cnt;
      repeat (8) @(posedge clk);
      chk("early_send", n, p.got_cnt);
      wait_tx(40);
      wr_reg(A_ROUT_LO, 32'h7);
      wait_tx(12);
      chk("pairs", pr(64'h80000001_00000007), p.got_pairs);
      wr_reg(A_DEV_ID, 32'ha1);
      wr_reg(A_DEV_ID + 8'h0f, 32'hb0);
      for (int i = 0; i < 5; i++) wr_reg(8'(A_RIN_CFG + i), 32'(cfg[i]));
      repeat (2) @(posedge clk);
      chk("rin", 5'b00110, rin[4:0]);
      p.send(32'ha2, 3, pr(64'h48));
      chk("offline", 16'hffff, offline);
      repeat (4) begin
         repeat (6) @(posedge clk);
         p.send(32'ha1, 3, pr(64'h48));
      end
      p.send(32'hb0, 3, pr(64'h48));
      chk("offline", 16'h7ffe, offline);
      chk("rin", 5'b11001, rin[4:0]);
      rd_reg(A_STATUS, d);
      chk("status", 16'h7ffe, d[15:0]);
      rd_reg(A_RIN_VAL, d);
      chk("rin_reg", 5'b11001, d[4:0]);
      rd_reg(8'h80, d);
      chk("unmapped", 0, d);
      repeat (40) @(posedge clk);
      chk("offline", 16'hffff, offline);
      chk("rin", 5'b01010, rin[4:0]);
      print_verdict();
   end
endmodule
